/* File: hw/thermal_energy_pkg.sv */
// How it works
// RULE1: Every energy and product register is evaluated on every integration.
// RULE2: Energy in Wh is volume times difference times coefficient times 1000.
// RULE3: Wh converts to kWh, MWh or GJ by 1000, 1000000 or 277800.
// RULE4: Water heat coefficient follows temperature at a fixed 16 bar.
// RULE5: Heat difference is inlet minus outlet temperature.
// RULE6: Cooling difference is outlet minus inlet temperature.
// RULE7: Heat energy grows only while inlet is warmer than outlet.
// RULE8: Equal inlet and outlet add zero to heat, discount and addition.
// RULE9: Cooling energy grows only while inlet is colder than outlet.
// RULE10: Discount uses reference minus outlet temperature difference.
// RULE11: Addition uses outlet minus reference temperature difference.
// RULE12: Discount and addition add nothing for zero or negative difference.
// RULE13: Outlet reference is a writable setting, 50 degrees after reset.
// RULE14: A failed sensor stops every register that depends on it.
// RULE15: Inlet and outlet products add volume times that temperature.
// RULE16: Third temperature products use primary and secondary volume.
// RULE17: Product scaling follows the number of volume decimals.
// RULE18: Readers capture volume together with the product registers; the code captures nothing, each APB read returns one live register.
// RULE19: Installers trim sensor offsets since discount needs absolute accuracy.
// RULE20: One strobe runs all accumulations, finished before the next strobe.
// RULE21: Fractions left after unit conversion are kept for later steps.
package thermal_energy_pkg;

	localparam int ADDR_W  = 12;
	localparam int TEMP_W  = 16;
	localparam int VOL_W   = 16;
	localparam int K_W     = 16;
	localparam int PROD_W  = 48;
	localparam int DIV_W   = 50;
	localparam int CNT_W   = 6;
	localparam int NUM_ACC = 8;
	localparam int IDX_W   = 3;
	localparam int CTRL_W  = 8;

	localparam logic [ADDR_W-1:0] ADDR_CTRL       = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_OUTLET_REF = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_TOTAL_BASE = 12'h010;
	localparam logic [ADDR_W-1:0] ADDR_VOLUME     = 12'h030;

	localparam int CTRL_UNIT_LSB   = 0;
	localparam int CTRL_RES_LSB    = 2;
	localparam int CTRL_OUTLET_BIT = 4;
	localparam int CTRL_ENABLE_BIT = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h2c;
	localparam logic [TEMP_W-1:0] OUTLET_REF_RESET = 16'h1388;

	localparam int STATUS_BUSY_BIT    = 0;
	localparam int STATUS_OVERRUN_BIT = 1;
	localparam int STATUS_ERR_LSB     = 4;

	localparam logic [1:0] UNIT_KWH = 2'h0;
	localparam logic [1:0] UNIT_MWH = 2'h1;
	localparam logic [1:0] UNIT_GJ  = 2'h2;

	// Raw products are litres x 0.01 K x 0.0001 kWh/m3/K.
	localparam longint unsigned LITRE_PER_M3  = 1000;
	localparam longint unsigned CENTI_PER_K   = 100;
	localparam longint unsigned K_SCALE       = 10000;
	localparam longint unsigned WH_FACTOR     = 1000;
	localparam longint unsigned RAW_PER_WH    =
		LITRE_PER_M3 * CENTI_PER_K * K_SCALE / WH_FACTOR;
	localparam longint unsigned WH_PER_KWH    = 1000;
	localparam longint unsigned WH_PER_MWH    = 1000000;
	localparam longint unsigned WH_PER_GJ     = 277800;
	localparam longint unsigned DIV_KWH = RAW_PER_WH * WH_PER_KWH;
	localparam longint unsigned DIV_MWH = RAW_PER_WH * WH_PER_MWH;
	localparam longint unsigned DIV_GJ  = RAW_PER_WH * WH_PER_GJ;

	// Product raw unit is litre x 0.01 degC; three decimals give 0.1 m3 degC.
	localparam longint unsigned PROD_DIV_3DEC = 10000;
	localparam longint unsigned PROD_DIV_2DEC = 100000;
	localparam longint unsigned PROD_DIV_1DEC = 1000000;
	localparam longint unsigned PROD_DIV_0DEC = 10000000;

	localparam int K_TABLE_DEPTH = 17;
	localparam int K_STEP_CENTI  = 1000;

endpackage

/* File: hw/heat_coeff_rom.sv */
`timescale 1ns/1ps
module heat_coeff_rom
	import thermal_energy_pkg::*;
(
	// Clock, reset and clock enable.
	input  wire logic                     i_clk,
	input  wire logic                     i_reset,
	input  wire logic                     i_clk_en,
	// Lookup.
	input  wire logic signed [TEMP_W-1:0] i_temperature,
	output logic             [K_W-1:0]    o_heat_coeff
);

	// Coefficient at 16 bar in 0.0001 kWh/m3/K, one entry per 10 degC.
	localparam logic [K_W-1:0] K_TABLE [K_TABLE_DEPTH] = '{
		16'h2d6e, 16'h2d64, 16'h2d50, 16'h2d32, 16'h2d00,
		16'h2cce, 16'h2c92, 16'h2c56, 16'h2c10, 16'h2bc0,
		16'h2b70, 16'h2b16, 16'h2abc, 16'h2a58, 16'h29f4,
		16'h2986, 16'h2918
	};

	logic [TEMP_W:0] rounded;
	logic [TEMP_W:0] raw_index;
	logic [4:0]      index;

	assign rounded   = (i_temperature < 0) ? '0 :
		(TEMP_W+1)'(i_temperature) + (TEMP_W+1)'(K_STEP_CENTI / 2);
	assign raw_index = rounded / (TEMP_W+1)'(K_STEP_CENTI);
	assign index     = (raw_index > (TEMP_W+1)'(K_TABLE_DEPTH - 1)) ?
		5'(K_TABLE_DEPTH - 1) : raw_index[4:0];

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_heat_coeff <= '0;
		end else if (i_clk_en) begin
			o_heat_coeff <= K_TABLE[index]; // [RULE4]
		end
	end

endmodule

/* File: hw/thermal_energy_accumulator.sv */
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module thermal_energy_accumulator
	import thermal_energy_pkg::*;
#(
	parameter int ACC_W = 32
) (
	// Clock, reset and clock enable.
	input  wire logic                     i_clk,
	input  wire logic                     i_reset,
	input  wire logic                     i_clk_en,
	// APB register port.
	input  wire logic                     i_psel,
	input  wire logic                     i_penable,
	input  wire logic                     i_pwrite,
	input  wire logic        [ADDR_W-1:0] i_paddr,
	input  wire logic        [31:0]       i_pwdata,
	output logic             [31:0]       o_prdata,
	output logic                          o_pready,
	output logic                          o_pslverr,
	// Measurement front end.
	input  wire logic                     i_integrate_strobe,
	input  wire logic signed [TEMP_W-1:0] i_inlet_temperature,
	input  wire logic signed [TEMP_W-1:0] i_outlet_temperature,
	input  wire logic signed [TEMP_W-1:0] i_third_temperature,
	input  wire logic        [VOL_W-1:0]  i_primary_volume,
	input  wire logic        [VOL_W-1:0]  i_secondary_volume,
	input  wire logic        [3:0]        i_sensor_error,
	// Status.
	output logic                          o_busy
);

	if (ACC_W < 16 || ACC_W > 32) begin : g_bad_acc_w
		$error("ACC_W must lie between 16 and 32");
	end

	typedef enum logic [2:0] {
		st_idle,
		st_fetch,
		st_load,
		st_div,
		st_store
	} state_e;

	// Clamp a signed difference to its positive part.
	function automatic logic [TEMP_W-1:0] pos_diff(
		input logic signed [TEMP_W-1:0] a,
		input logic signed [TEMP_W-1:0] b
	);
		logic signed [TEMP_W:0] d;
		d = (TEMP_W+1)'(a) - (TEMP_W+1)'(b);
		pos_diff = (d > 0) ? d[TEMP_W-1:0] : '0;
	endfunction

	function automatic logic [PROD_W-1:0] mul3(
		input logic [VOL_W-1:0]  v,
		input logic [TEMP_W-1:0] dt,
		input logic [K_W-1:0]    k
	);
		mul3 = PROD_W'(v) * PROD_W'(dt) * PROD_W'(k);
	endfunction

	function automatic logic [PROD_W-1:0] mul2(
		input logic [VOL_W-1:0]  v,
		input logic [TEMP_W-1:0] t
	);
		mul2 = PROD_W'(v) * PROD_W'(t);
	endfunction

	function automatic logic [DIV_W-1:0] divisor_for(
		input logic [IDX_W-1:0] n,
		input logic [1:0]       unit,
		input logic [1:0]       res
	);
		logic [63:0] d;
		d = PROD_DIV_0DEC;
		if (n < IDX_W'(4)) begin
			unique case (unit)
				UNIT_KWH: d = DIV_KWH;
				UNIT_MWH: d = DIV_MWH;
				default:  d = DIV_GJ;
			endcase
		end else begin
			unique case (res)
				2'h3: d = PROD_DIV_3DEC;
				2'h2: d = PROD_DIV_2DEC;
				2'h1: d = PROD_DIV_1DEC;
				2'h0: d = PROD_DIV_0DEC;
			endcase
		end
		divisor_for = d[DIV_W-1:0];
	endfunction

	state_e                    state;
	logic [CTRL_W-1:0]         ctrl;
	logic signed [TEMP_W-1:0]  outlet_temperature_reference;
	logic                      overrun;
	logic signed [TEMP_W-1:0]  inlet_temperature;
	logic signed [TEMP_W-1:0]  outlet_temperature;
	logic signed [TEMP_W-1:0]  third_temperature;
	logic [VOL_W-1:0]          primary_volume;
	logic [VOL_W-1:0]          secondary_volume;
	logic [3:0]                sensor_error;
	logic [K_W-1:0]            heat_coeff;
	logic [ACC_W-1:0]          total [NUM_ACC];
	logic [DIV_W-1:0]          residue [NUM_ACC];
	logic [31:0]               volume_total;
	logic [IDX_W-1:0]          idx;
	logic [DIV_W-1:0]          dividend;
	logic [DIV_W-1:0]          quotient;
	logic [DIV_W-1:0]          remain;
	logic [DIV_W-1:0]          divisor;
	logic [CNT_W-1:0]          cnt;

	// Front-end decode.
	logic                      accept;
	logic                      heat_flow;
	logic                      cool_flow;
	logic [TEMP_W-1:0]         dt_heat;
	logic [TEMP_W-1:0]         dt_cool;
	logic [TEMP_W-1:0]         dt_discount;
	logic [TEMP_W-1:0]         dt_addition;
	logic [PROD_W-1:0]         inc [NUM_ACC];
	logic [NUM_ACC-1:0]        inc_live;
	logic                      pair_ok;
	logic signed [TEMP_W-1:0]  k_temperature;

	assign accept = i_integrate_strobe && state == st_idle &&
		ctrl[CTRL_ENABLE_BIT]; // [RULE20]
	assign k_temperature = ctrl[CTRL_OUTLET_BIT] ? outlet_temperature :
		inlet_temperature;

	heat_coeff_rom u_heat_coeff_rom (
		.i_clk         (i_clk),
		.i_reset       (i_reset),
		.i_clk_en      (i_clk_en),
		.i_temperature (k_temperature),
		.o_heat_coeff  (heat_coeff)
	);

	assign heat_flow   = inlet_temperature > outlet_temperature; // [RULE7]
	assign cool_flow   = inlet_temperature < outlet_temperature; // [RULE9]
	// Equal temperatures give a zero difference and so add nothing.
	assign dt_heat     = pos_diff(inlet_temperature,
		outlet_temperature); // [RULE5] [RULE8]
	assign dt_cool     = pos_diff(outlet_temperature,
		inlet_temperature); // [RULE6]
	assign dt_discount = pos_diff(outlet_temperature_reference,
		outlet_temperature); // [RULE10] [RULE12]
	assign dt_addition = pos_diff(outlet_temperature,
		outlet_temperature_reference); // [RULE11] [RULE12]

	// All eight increments exist at once; the divider walks them in turn.
	assign inc[0] = heat_flow ?
		mul3(primary_volume, dt_heat, heat_coeff) : '0; // [RULE1] [RULE2]
	assign inc[1] = cool_flow ?
		mul3(primary_volume, dt_cool, heat_coeff) : '0; // [RULE2]
	assign inc[2] = heat_flow ?
		mul3(primary_volume, dt_discount, heat_coeff) : '0; // [RULE8]
	assign inc[3] = heat_flow ?
		mul3(primary_volume, dt_addition, heat_coeff) : '0; // [RULE8]
	assign inc[4] = mul2(primary_volume,
		pos_diff(inlet_temperature, '0)); // [RULE15]
	assign inc[5] = mul2(primary_volume,
		pos_diff(outlet_temperature, '0)); // [RULE15]
	assign inc[6] = mul2(primary_volume,
		pos_diff(third_temperature, '0)); // [RULE16]
	assign inc[7] = mul2(secondary_volume,
		pos_diff(third_temperature, '0)); // [RULE16]

	assign pair_ok  = !sensor_error[0] && !sensor_error[1];
	assign inc_live = {
		!sensor_error[2],
		!sensor_error[2],
		!sensor_error[1],
		!sensor_error[0],
		{4{pair_ok}}
	}; // [RULE14]

	// Restoring division step.
	logic [DIV_W-1:0] rem_shift;
	logic             rem_fits;
	logic [DIV_W-1:0] next_remain;
	logic [DIV_W-1:0] next_dividend;
	logic [DIV_W-1:0] next_divisor;
	logic             last_idx;

	assign rem_shift   = {remain[DIV_W-2:0], dividend[DIV_W-1]};
	assign rem_fits    = rem_shift >= divisor;
	assign next_remain = rem_fits ? rem_shift - divisor : rem_shift;
	assign next_dividend = residue[idx] + DIV_W'(inc[idx]); // [RULE21]
	assign next_divisor  = divisor_for(idx,
		ctrl[CTRL_UNIT_LSB +: 2], ctrl[CTRL_RES_LSB +: 2]); // [RULE3] [RULE17]
	assign last_idx    = idx == IDX_W'(NUM_ACC - 1);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= st_idle;
		end else if (i_clk_en) begin
			unique case (state)
				st_idle:  state <= accept ? st_fetch : st_idle;
				st_fetch: state <= st_load;
				st_load:  state <= inc_live[idx] ? st_div :
					(last_idx ? st_idle : st_load);
				st_div:   state <= (cnt == CNT_W'(1)) ? st_store : st_div;
				st_store: state <= last_idx ? st_idle : st_load;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			inlet_temperature  <= '0;
			outlet_temperature <= '0;
			third_temperature  <= '0;
			primary_volume     <= '0;
			secondary_volume   <= '0;
			sensor_error       <= '0;
		end else if (i_clk_en && accept) begin
			inlet_temperature  <= i_inlet_temperature;
			outlet_temperature <= i_outlet_temperature;
			third_temperature  <= i_third_temperature;
			primary_volume     <= i_primary_volume;
			secondary_volume   <= i_secondary_volume;
			sensor_error       <= i_sensor_error;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			idx      <= '0;
			dividend <= '0;
			quotient <= '0;
			remain   <= '0;
			divisor  <= '0;
			cnt      <= '0;
		end else if (i_clk_en) begin
			if (state == st_fetch) begin
				idx <= '0;
			end else if (state == st_load && inc_live[idx]) begin
				dividend <= next_dividend;
				divisor  <= next_divisor;
				quotient <= '0;
				remain   <= '0;
				cnt      <= CNT_W'(DIV_W);
			end else if (state == st_load || state == st_store) begin
				idx <= idx + IDX_W'(1);
			end else if (state == st_div) begin
				dividend <= {dividend[DIV_W-2:0], 1'b0};
				quotient <= {quotient[DIV_W-2:0], rem_fits};
				remain   <= next_remain;
				cnt      <= cnt - CNT_W'(1);
			end
		end
	end

	// A register of a failed sensor is never loaded, so it stands still.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			for (int n = 0; n < NUM_ACC; n++) begin
				total[n]   <= '0;
				residue[n] <= '0;
			end
		end else if (i_clk_en && state == st_store) begin
			total[idx]   <= total[idx] + quotient[ACC_W-1:0]; // [RULE3]
			residue[idx] <= remain; // [RULE21]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			volume_total <= '0;
		end else if (i_clk_en && state == st_fetch) begin
			volume_total <= volume_total + 32'(primary_volume);
		end
	end

	// APB decode.
	logic [ADDR_W-1:0] total_off;
	logic              total_hit;
	logic [IDX_W-1:0]  total_idx;
	logic              ctrl_hit;
	logic              ref_hit;
	logic              status_hit;
	logic              volume_hit;
	logic              addr_hit;
	logic              wr_access;
	logic [31:0]       status_word;
	logic [31:0]       read_word;
	logic              overrun_clear;

	assign total_off  = i_paddr - ADDR_TOTAL_BASE;
	assign total_hit  = total_off[ADDR_W-1:5] == '0 &&
		total_off[1:0] == 2'h0;
	assign total_idx  = total_off[4:2];
	assign ctrl_hit   = i_paddr == ADDR_CTRL;
	assign ref_hit    = i_paddr == ADDR_OUTLET_REF;
	assign status_hit = i_paddr == ADDR_STATUS;
	assign volume_hit = i_paddr == ADDR_VOLUME;
	assign addr_hit   = ctrl_hit || ref_hit || status_hit || volume_hit ||
		total_hit;
	assign wr_access  = i_psel && i_penable && i_pwrite && i_clk_en;

	assign status_word = {24'h0, sensor_error, 2'h0, overrun,
		state != st_idle};
	assign read_word =
		ctrl_hit   ? 32'(ctrl) :
		ref_hit    ? 32'(unsigned'(outlet_temperature_reference)) :
		status_hit ? status_word :
		volume_hit ? volume_total :
		total_hit  ? 32'(total[total_idx]) : 32'h0;

	assign overrun_clear = wr_access && status_hit &&
		i_pwdata[STATUS_OVERRUN_BIT];

	assign o_pready = i_clk_en;
	assign o_busy   = state != st_idle;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_prdata  <= '0;
			o_pslverr <= 1'b0;
		end else if (i_clk_en && i_psel && !i_penable) begin
			o_prdata  <= i_pwrite ? 32'h0 : read_word;
			o_pslverr <= !addr_hit;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ctrl                         <= CTRL_RESET;
			outlet_temperature_reference <= OUTLET_REF_RESET; // [RULE13]
		end else if (wr_access && ctrl_hit) begin
			ctrl <= i_pwdata[CTRL_W-1:0];
		end else if (wr_access && ref_hit) begin
			outlet_temperature_reference <= i_pwdata[TEMP_W-1:0]; // [RULE13]
		end
	end

	// A strobe while busy is dropped; the sticky flag wins over a clear.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			overrun <= 1'b0;
		end else if (i_clk_en) begin
			if (i_integrate_strobe && state != st_idle) begin
				overrun <= 1'b1; // [RULE20]
			end else if (overrun_clear) begin
				overrun <= 1'b0;
			end
		end
	end

endmodule

/* File: bench/flow_front_end.sv */
`timescale 1ns/1ps
module flow_front_end
	import thermal_energy_pkg::*;
(
	// Clock and request.
	input  wire logic                        i_clk,
	input  wire logic                        i_fire,
	input  wire logic [3*TEMP_W+2*VOL_W+3:0] i_sample,
	// Towards the accumulator.
	output logic                             o_strobe = 1'b0,
	output logic [3*TEMP_W+2*VOL_W+3:0]      o_sample = '0
);
	// Samples stay put between strobes, as a real front end holds them.
	// Temperatures come with sensor offsets already trimmed at install.
	always_ff @(posedge i_clk) begin
		o_strobe <= i_fire;
		if (i_fire) begin
			o_sample <= i_sample;
		end
	end
endmodule

/* File: bench/thermal_energy_accumulator_checker.sv */
`timescale 1ns/1ps
module thermal_energy_accumulator_checker
	import thermal_energy_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic              i_clk,
	input wire logic              i_reset,
	input wire logic              i_clk_en,
	// APB register port.
	input wire logic              i_psel,
	input wire logic              i_penable,
	input wire logic              i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0]       o_prdata,
	input wire logic              o_pready,
	input wire logic              o_pslverr,
	// Integration.
	input wire logic              i_integrate_strobe,
	input wire logic              o_busy
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	wire logic aligned   = i_paddr[1:0] == 2'h0;
	wire logic mapped    = aligned && i_paddr <= ADDR_VOLUME &&
		i_paddr != 12'h00c;
	wire logic acc_phase = i_psel && i_penable;
	logic [9:0] busy_cycles;

	always_ff @(posedge i_clk) begin
		if (i_reset || !o_busy) begin
			busy_cycles <= 10'h000;
		end else if (i_clk_en) begin
			busy_cycles <= busy_cycles + 10'h001;
		end
	end

	a_ready_tracks_en: assert property (o_pready == i_clk_en)
		else $error("pready differs from clock enable");
	a_busy_cause: assert property ($rose(o_busy) |->
		$past(i_integrate_strobe) && $past(i_clk_en))
		else $error("busy rose without a strobe");
	a_busy_all_regs: assert property ($rose(o_busy) |-> o_busy[*8])
		else $error("step ended too early");
	a_busy_bounded: assert property (busy_cycles <= 10'h1a2)
		else $error("step longer than allowed");
	a_busy_frozen: assert property (!i_clk_en |=> $stable(o_busy))
		else $error("busy moved while disabled");
	a_reset_clean: assert property ($past(i_reset) && $past(i_clk_en) |->
		!o_busy && o_prdata == 32'h0 && !o_pslverr)
		else $error("outputs not clear after reset");
	a_write_zero: assert property (i_psel && !i_penable && i_pwrite &&
		i_clk_en |=> o_prdata == 32'h0)
		else $error("read data not zero on write");
	a_prdata_holds: assert property (acc_phase && o_pready |=>
		$stable(o_prdata))
		else $error("read data changed after access");
	a_err_unmapped: assert property (acc_phase && aligned && !mapped |->
		o_pslverr)
		else $error("no error for unmapped address");
	a_err_mapped: assert property (acc_phase && mapped |-> !o_pslverr)
		else $error("error for mapped address");

	c_step: cover property ($rose(o_busy));
	c_error: cover property (acc_phase && o_pslverr);
	c_write: cover property (acc_phase && i_pwrite && o_pready);
endmodule

bind thermal_energy_accumulator thermal_energy_accumulator_checker chk (
	.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .i_integrate_strobe(i_integrate_strobe),
	.o_busy(o_busy));

/* File: bench/thermal_energy_accumulator_tb.sv */
`timescale 1ns/1ps
module thermal_energy_accumulator_tb import thermal_energy_pkg::*;;
	localparam int SW = 3 * TEMP_W + 2 * VOL_W + 4;
	logic              clk    = 1'b0;
	logic              rst    = 1'b1;
	logic              en     = 1'b1;
	logic              psel   = 1'b0;
	logic              pen    = 1'b0;
	logic              pwr    = 1'b0;
	logic [ADDR_W-1:0] paddr  = '0;
	logic [31:0]       pwdata = '0;
	logic              fire   = 1'b0;
	logic [SW-1:0]     smp    = '0;
	logic [SW-1:0]     fe;
	logic              strobe, pready, pslverr, busy, err;
	logic [31:0]       prdata, q;
	int                bad_count       = 0;
	int                samples_checked = 0;

	flow_front_end fe_model (.i_clk(clk), .i_fire(fire), .i_sample(smp),
		.o_strobe(strobe), .o_sample(fe));
	thermal_energy_accumulator dut (.i_clk(clk), .i_reset(rst),
		.i_clk_en(en), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr),
		.i_integrate_strobe(strobe), .i_inlet_temperature(fe[15:0]),
		.i_outlet_temperature(fe[31:16]), .i_third_temperature(fe[47:32]),
		.i_primary_volume(fe[63:48]), .i_secondary_volume(fe[79:64]),
		.i_sensor_error(fe[83:80]), .o_busy(busy));

	initial begin
		forever #10 clk = ~clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic fail(input string m);
		bad_count++;
		$display("ERROR %0t %s", $time, m);
	endtask

	task automatic wait_for(input logic on_busy, input logic v);
		for (int n = 0; n < 600; n++) begin
			@(posedge clk);
			if ((on_busy ? busy : pready) === v) return;
		end
		fail("wait timed out");
		final_report();
	endtask

	function automatic logic [ADDR_W-1:0] tot(input int n);
		return ADDR_TOTAL_BASE + ADDR_W'(4 * n);
	endfunction

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		wait_for(1'b0, 1'b1);
		q    = prdata;
		err  = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	task automatic chk(input logic [ADDR_W-1:0] a, input logic [31:0] lo, hi);
		apb(1'b0, a, 32'h0);
		samples_checked++;
		if ((q >= lo) !== 1'b1 || (q <= hi) !== 1'b1 || err !== 1'b0) begin
			fail($sformatf("reg %h read %0d", a, q));
		end
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
	endtask

	// The enable drops for one cycle in st_fetch, right after the strobe is taken, to exercise the freeze.
	task automatic step(input logic [15:0] ti, to, tt, pv, sv,
		input logic [3:0] e);
		@(posedge clk);
		fire <= 1'b1;
		smp  <= {e, sv, pv, tt, to, ti};
		@(posedge clk);
		fire <= 1'b0;
		@(posedge clk);
		en <= 1'b0;
		@(posedge clk);
		en <= 1'b1;
		wait_for(1'b1, 1'b0);
	endtask

	task automatic t_heat();
		do_reset();
		chk(ADDR_CTRL, 32'h2c, 32'h2c);
		chk(ADDR_OUTLET_REF, 32'h1388, 32'h1388);
		apb(1'b1, tot(0), 32'h1234);
		apb(1'b0, 12'h0fc, 32'h0);
		samples_checked++;
		if (err !== 1'b1 || q !== 32'h0) fail("unmapped read");
		step(16'h1b58, 16'h0bb8, 16'h0fa0, 16'h03e8, 16'h01f4, 4'h0);
		chk(tot(0), 32'h2b, 32'h30);
		chk(tot(1), 32'h0, 32'h0);
		chk(tot(2), 32'h15, 32'h18);
		chk(tot(3), 32'h0, 32'h0);
		chk(tot(4), 32'h2bc, 32'h2bc);
		chk(tot(5), 32'h12c, 32'h12c);
		chk(tot(6), 32'h190, 32'h190);
		chk(tot(7), 32'hc8, 32'hc8);
		chk(ADDR_VOLUME, 32'h3e8, 32'h3e8);
		$display("test heat done");
	endtask

	task automatic t_add();
		do_reset();
		apb(1'b1, ADDR_OUTLET_REF, 32'h07d0);
		chk(ADDR_OUTLET_REF, 32'h7d0, 32'h7d0);
		// Coefficient taken at the outlet temperature this time.
		apb(1'b1, ADDR_CTRL, 32'h3c);
		step(16'h1b58, 16'h0bb8, 16'h0fa0, 16'h03e8, 16'h0, 4'h0);
		chk(tot(2), 32'h0, 32'h0);
		chk(tot(3), 32'ha, 32'hc);
		chk(tot(0), 32'h2e, 32'h2e);
		$display("test addition done");
	endtask

	task automatic t_cool();
		do_reset();
		step(16'h03e8, 16'h07d0, 16'h0fa0, 16'h2710, 16'h0, 4'h0);
		step(16'h0fa0, 16'h0fa0, 16'h0fa0, 16'h03e8, 16'h0, 4'h0);
		chk(tot(0), 32'h0, 32'h0);
		chk(tot(1), 32'h72, 32'h76);
		chk(tot(2), 32'h0, 32'h0);
		chk(tot(3), 32'h0, 32'h0);
		chk(tot(4), 32'h578, 32'h578);
		$display("test cooling done");
	endtask

	task automatic t_err();
		do_reset();
		step(16'h1b58, 16'h0bb8, 16'h0fa0, 16'h03e8, 16'h01f4, 4'h1);
		step(16'h1b58, 16'h0bb8, 16'h0fa0, 16'h03e8, 16'h01f4, 4'h4);
		chk(tot(0), 32'h2b, 32'h30);
		chk(tot(2), 32'h15, 32'h18);
		chk(tot(4), 32'h2bc, 32'h2bc);
		chk(tot(5), 32'h258, 32'h258);
		chk(tot(6), 32'h190, 32'h190);
		chk(ADDR_VOLUME, 32'h7d0, 32'h7d0);
		chk(ADDR_STATUS, 32'h40, 32'h40);
		$display("test sensor error done");
	endtask

	task automatic t_frac();
		do_reset();
		repeat (3) step(16'h1b58, 16'h0bb8, 16'h05dc, 16'h000a, 16'h0, 4'h0);
		chk(tot(0), 32'h1, 32'h1);
		chk(tot(6), 32'h4, 32'h4);
		// A strobe two cycles long: its second half arrives while busy.
		@(posedge clk);
		fire <= 1'b1;
		repeat (2) @(posedge clk);
		fire <= 1'b0;
		wait_for(1'b1, 1'b0);
		chk(ADDR_STATUS, 32'h2, 32'h2);
		apb(1'b1, ADDR_STATUS, 32'h2);
		chk(ADDR_STATUS, 32'h0, 32'h0);
		$display("test remainder done");
	endtask

	task automatic t_units();
		logic [31:0] lo [4] = '{32'hb2c, 32'h2, 32'ha, 32'ha};
		logic [31:0] hi [4] = '{32'hbea, 32'h3, 32'hb, 32'hb};
		for (int u = 0; u < 4; u++) begin
			do_reset();
			apb(1'b1, ADDR_CTRL, {24'h0, CTRL_RESET | CTRL_W'(u)});
			step(16'h1b58, 16'h0bb8, 16'h0fa0, 16'hfde8, 16'h0, 4'h0);
			chk(tot(0), lo[u], hi[u]);
		end
		$display("test units done");
	endtask

	task automatic t_res();
		logic [31:0] want [4] = '{32'h2a, 32'h1a4, 32'h1068, 32'ha410};
		for (int r = 0; r < 4; r++) begin
			do_reset();
			apb(1'b1, ADDR_CTRL, {24'h0, CTRL_RESET & 8'hf3 | CTRL_W'(r << 2)});
			step(16'h1b58, 16'h0bb8, 16'h0fa0, 16'hea60, 16'h0, 4'h0);
			chk(tot(4), want[r], want[r]);
		end
		$display("test resolution done");
	endtask

	initial begin
		t_heat();
		t_add();
		t_cool();
		t_err();
		t_frac();
		t_units();
		t_res();
		final_report();
	end
endmodule
